//--- core/acr_clock_range_regs.sv
// Clock input, supply quieting, alignment position and full-scale registers
// Operation
// [RULE_01] Bit 2 of the clock input register puts the device clock input in PECL mode.
// [RULE_02] Bit 1 of the clock input register puts the alignment reference input in PECL mode.
// [RULE_03] Bit 0 of the clock input register inverts the alignment reference before use.
// [RULE_04] Software writes only default values into reserved bits of both clock registers.
// [RULE_05] Bit 2 of the supply register enables quieting of the quantizer supply.
// [RULE_06] Bit 0 of the supply register enables quieting of the clock path supply.
// [RULE_07] A read-only 24-bit word reports where the alignment edge fell against the clock.
// [RULE_08] Software uses the edge position word to choose the delay select value.
// [RULE_09] A 16-bit read/write full-scale field resets to 0xa000 and serves every channel.
// [RULE_10] Code 0x2000 means 500 mVPP, 0xffff means 1000 mVPP, lower codes degrade.
// [RULE_11] A 4-bit delay select field picks the alignment reference capture delay.
// [RULE_12] Writes to the edge position word are ignored and leave it unchanged.
`timescale 1ns/1ns
`default_nettype none
module acr_clock_range_regs (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        SCLK,
  input  wire logic        SCS_N,
  input  wire logic        SDI,
  output var  logic        SDO,
  output var  logic        SDO_OE,
  input  wire logic        ALIGN_REF_IN,
  input  wire logic [23:0] ALIGN_POS_IN,
  output var  logic        DEVCLOCK_PECL_MODE_ENABLE,
  output var  logic        ALIGNREF_PECL_MODE_ENABLE,
  output var  logic        ALIGNREF_POLARITY_INVERT,
  output var  logic        QUANTIZER_SUPPLY_QUIETING_ENABLE,
  output var  logic        CLOCKPATH_SUPPLY_QUIETING_ENABLE,
  output var  logic [3:0]  ALIGNREF_DELAY_SELECT,
  output var  logic        ALIGN_REF_ALIGNED,
  output var  logic [15:0] FULL_SCALE_SETTING,
  output var  logic        FULL_SCALE_DEGRADED
);
  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  acr_cfg_if cfg ();
  acr_spi_port u_port (
    .clk       (MCLK),
    .srst      (SRST),
    .sclk_pin  (SCLK),
    .scs_n_pin (SCS_N),
    .sdi_pin   (SDI),
    .sdo       (SDO),
    .sdo_oe    (SDO_OE),
    .cfg       (cfg.port)
  );
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  dctl_r, dctl_nxt, clkin_r, clkin_nxt, sup_r, sup_nxt;
  logic [15:0] fs_r, fs_nxt;
  logic        degr_r, degr_nxt;
  logic [23:0] pos_s1_r, pos_s2_r, pos_r, pos_nxt;
  logic        ref_s1_r, ref_s2_r;
  localparam int DELAY_W = acr_pkg::DELAY_TAPS;
  logic [DELAY_W-1:0] dl_r, dl_nxt;
  logic        algn_r, algn_nxt;

  function automatic logic [7:0] rd_mux(input logic [14:0] a, input logic [7:0] d,
                                        input logic [7:0] c, input logic [7:0] s,
                                        input logic [23:0] p, input logic [15:0] f);
    case (a)
      acr_pkg::ADDR_DELAY_CTRL: rd_mux = d;
      acr_pkg::ADDR_CLK_IN:     rd_mux = c;
      acr_pkg::ADDR_SUPPLY:     rd_mux = s;
      acr_pkg::ADDR_POS0:       rd_mux = p[7:0];
      acr_pkg::ADDR_POS1:       rd_mux = p[15:8];
      acr_pkg::ADDR_POS2:       rd_mux = p[23:16];
      acr_pkg::ADDR_FS0:        rd_mux = f[7:0];
      acr_pkg::ADDR_FS1:        rd_mux = f[15:8];
      default:                  rd_mux = 8'h00;
    endcase
  endfunction

  assign cfg.rdata = rd_mux(cfg.addr, dctl_r, clkin_r, sup_r, pos_r, fs_r); // [RULE_07]

  always_comb
  begin
    dctl_nxt  = dctl_r;
    clkin_nxt = clkin_r;
    sup_nxt   = sup_r;
    fs_nxt    = fs_r;
    if (cfg.wr_en)
    begin
      // Position bytes have no write path at all [RULE_12]
      case (cfg.addr)
        acr_pkg::ADDR_DELAY_CTRL: dctl_nxt      = cfg.wdata; // [RULE_11]
        acr_pkg::ADDR_CLK_IN:     clkin_nxt     = cfg.wdata; // [RULE_01] [RULE_02] [RULE_03]
        acr_pkg::ADDR_SUPPLY:     sup_nxt       = cfg.wdata; // [RULE_05] [RULE_06]
        acr_pkg::ADDR_FS0:        fs_nxt[7:0]   = cfg.wdata; // [RULE_09]
        acr_pkg::ADDR_FS1:        fs_nxt[15:8]  = cfg.wdata; // [RULE_09]
        default:                  fs_nxt        = fs_r;
      endcase
    end
    degr_nxt = fs_nxt < acr_pkg::FS_MIN_RECOMMENDED; // [RULE_10]
    // Word-wide sync: detector must hold the word steady between updates
    pos_nxt  = pos_s2_r; // [RULE_07]
    dl_nxt   = {dl_r[DELAY_W-2:0], ref_s2_r ^ clkin_r[acr_pkg::BIT_ALIGNREF_INV]}; // [RULE_03]
    algn_nxt = dl_r[dctl_r[acr_pkg::DSEL_MSB:0]]; // [RULE_11]
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      dctl_r   <= acr_pkg::RST_DELAY_CTRL;
      clkin_r  <= acr_pkg::RST_CLK_IN;
      sup_r    <= acr_pkg::RST_SUPPLY;
      fs_r     <= acr_pkg::RST_FS; // [RULE_09]
      degr_r   <= 1'b0;
      pos_s1_r <= acr_pkg::RST_POS;
      pos_s2_r <= acr_pkg::RST_POS;
      pos_r    <= acr_pkg::RST_POS;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      dl_r     <= '0;
      algn_r   <= 1'b0;
    end
    else
    begin
      dctl_r   <= dctl_nxt;
      clkin_r  <= clkin_nxt;
      sup_r    <= sup_nxt;
      fs_r     <= fs_nxt;
      degr_r   <= degr_nxt;
      pos_s1_r <= ALIGN_POS_IN;
      pos_s2_r <= pos_s1_r;
      pos_r    <= pos_nxt;
      ref_s1_r <= ALIGN_REF_IN;
      ref_s2_r <= ref_s1_r;
      dl_r     <= dl_nxt;
      algn_r   <= algn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DEVCLOCK_PECL_MODE_ENABLE        = clkin_r[acr_pkg::BIT_DEVICE_SAMPLE_CLOCK_PECL];   // [RULE_01]
  assign ALIGNREF_PECL_MODE_ENABLE        = clkin_r[acr_pkg::BIT_ALIGNREF_PECL]; // [RULE_02]
  assign ALIGNREF_POLARITY_INVERT         = clkin_r[acr_pkg::BIT_ALIGNREF_INV];  // [RULE_03]
  assign QUANTIZER_SUPPLY_QUIETING_ENABLE = sup_r[acr_pkg::BIT_QUANT_QUIET];     // [RULE_05]
  assign CLOCKPATH_SUPPLY_QUIETING_ENABLE = sup_r[acr_pkg::BIT_CLKPATH_QUIET];   // [RULE_06]
  assign ALIGNREF_DELAY_SELECT            = dctl_r[acr_pkg::DSEL_MSB:0];         // [RULE_11]
  assign ALIGN_REF_ALIGNED                = algn_r;
  assign FULL_SCALE_SETTING               = fs_r;                                // [RULE_09]
  assign FULL_SCALE_DEGRADED              = degr_r;                              // [RULE_10]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic wr_clk, wr_sup;
  assign wr_clk = cfg.wr_en && (cfg.addr == acr_pkg::ADDR_CLK_IN);
  assign wr_sup = cfg.wr_en && (cfg.addr == acr_pkg::ADDR_SUPPLY);

  sequence s_fixed_tap;
    (dctl_r[acr_pkg::DSEL_MSB:0] == 4'h3 && !clkin_r[acr_pkg::BIT_ALIGNREF_INV])[*6];
  endsequence
  sequence s_fs_write_lo;
    cfg.wr_en && cfg.addr == acr_pkg::ADDR_FS0;
  endsequence

  property p_device_sample_clock_pecl;
    @(posedge MCLK) disable iff (SRST)
    wr_clk |=> DEVCLOCK_PECL_MODE_ENABLE == $past(cfg.wdata[acr_pkg::BIT_DEVICE_SAMPLE_CLOCK_PECL]);
  endproperty
  a_device_sample_clock_pecl: assert property (p_device_sample_clock_pecl) else $error("devclock pecl bit wrong"); // [RULE_01]
  property p_alignref_pecl;
    @(posedge MCLK) disable iff (SRST)
    wr_clk |=> ALIGNREF_PECL_MODE_ENABLE == $past(cfg.wdata[acr_pkg::BIT_ALIGNREF_PECL]);
  endproperty
  a_alignref_pecl: assert property (p_alignref_pecl) else $error("alignref pecl bit wrong"); // [RULE_02]
  property p_invert;
    @(posedge MCLK) disable iff (SRST)
    (dctl_r[acr_pkg::DSEL_MSB:0] == 4'h0) |=>
      ALIGN_REF_ALIGNED == ($past(ref_s2_r, 2) ^ $past(ALIGNREF_POLARITY_INVERT, 2));
  endproperty
  a_invert: assert property (p_invert) else $error("alignref polarity wrong"); // [RULE_03]
  property p_quant_quiet;
    @(posedge MCLK) disable iff (SRST)
    wr_sup |=> QUANTIZER_SUPPLY_QUIETING_ENABLE == $past(cfg.wdata[acr_pkg::BIT_QUANT_QUIET]);
  endproperty
  a_quant_quiet: assert property (p_quant_quiet) else $error("quantizer quieting wrong"); // [RULE_05]
  property p_clkpath_quiet;
    @(posedge MCLK) disable iff (SRST)
    wr_sup |=> CLOCKPATH_SUPPLY_QUIETING_ENABLE == $past(cfg.wdata[acr_pkg::BIT_CLKPATH_QUIET]);
  endproperty
  a_clkpath_quiet: assert property (p_clkpath_quiet) else $error("clock path quieting wrong"); // [RULE_06]
  property p_pos_read;
    @(posedge MCLK) disable iff (SRST)
    (cfg.addr == acr_pkg::ADDR_POS1) |-> cfg.rdata == pos_r[15:8];
  endproperty
  a_pos_read: assert property (p_pos_read) else $error("position read wrong"); // [RULE_07]
  property p_pos_ro;
    @(posedge MCLK) disable iff (SRST)
    (cfg.wr_en && cfg.addr == acr_pkg::ADDR_POS0) |=> pos_r == $past(pos_s2_r);
  endproperty
  a_pos_ro: assert property (p_pos_ro) else $error("position took a write"); // [RULE_12]
  property p_fs_reset;
    @(posedge MCLK) disable iff (SRST)
    $fell(SRST) |-> FULL_SCALE_SETTING == acr_pkg::RST_FS;
  endproperty
  a_fs_reset: assert property (p_fs_reset) else $error("full scale reset wrong"); // [RULE_09]
  property p_fs_write;
    @(posedge MCLK) disable iff (SRST)
    s_fs_write_lo |=> FULL_SCALE_SETTING == {$past(fs_r[15:8]), $past(cfg.wdata)};
  endproperty
  a_fs_write: assert property (p_fs_write) else $error("full scale write wrong"); // [RULE_09]
  property p_degraded;
    @(posedge MCLK) disable iff (SRST)
    FULL_SCALE_DEGRADED == (FULL_SCALE_SETTING < acr_pkg::FS_MIN_RECOMMENDED);
  endproperty
  a_degraded: assert property (p_degraded) else $error("degraded flag wrong"); // [RULE_10]
  property p_delay_tap;
    @(posedge MCLK) disable iff (SRST)
    s_fixed_tap |-> ALIGN_REF_ALIGNED == $past(ref_s2_r, 5);
  endproperty
  a_delay_tap: assert property (p_delay_tap) else $error("delay tap wrong"); // [RULE_11]
endmodule // acr_clock_range_regs
`default_nettype wire

//--- core/acr_spi_port.sv
// Configuration serial port: pin synchronisers and byte framing
`timescale 1ns/1ns
`default_nettype none
module acr_spi_port (
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  sclk_pin,
  input  wire logic  scs_n_pin,
  input  wire logic  sdi_pin,
  output var  logic  sdo,
  output var  logic  sdo_oe,
  acr_cfg_if.port    cfg
);
  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r, cs_s1_r, cs_s2_r, sdi_s1_r, sdi_s2_r;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
      {cs_s1_r, cs_s2_r}                <= 2'h3;
      {sdi_s1_r, sdi_s2_r}              <= 2'h0;
    end
    else
    begin
      sclk_s1_r <= sclk_pin;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r   <= scs_n_pin;
      cs_s2_r   <= cs_s1_r;
      sdi_s1_r  <= sdi_pin;
      sdi_s2_r  <= sdi_s1_r;
    end
  end
  logic rise, fall;
  assign rise = sclk_s2_r & ~sclk_s3_r;
  assign fall = ~sclk_s2_r & sclk_s3_r;
  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  acr_pkg::acr_spi_state_t st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic        rw_r, rw_nxt, wr_r, wr_nxt, ld_r, ld_nxt, sdo_r, sdo_nxt;
  logic [14:0] addr_r, addr_nxt;
  logic [7:0]  tx_r, tx_nxt, wd_r, wd_nxt;
  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    rw_nxt   = rw_r;
    addr_nxt = addr_r;
    wr_nxt   = 1'b0;
    ld_nxt   = 1'b0;
    tx_nxt   = tx_r;
    sdo_nxt  = sdo_r;
    wd_nxt   = wd_r;
    case (st_r)
      acr_pkg::ST_IDLE:
        if (!cs_s2_r)
        begin
          st_nxt  = acr_pkg::ST_HDR;
          cnt_nxt = 4'h0;
        end
      acr_pkg::ST_HDR:
        if (rise)
        begin
          sh_nxt  = {sh_r[14:0], sdi_s2_r};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == acr_pkg::HDR_LAST)
          begin
            rw_nxt   = sh_r[14];
            addr_nxt = {sh_r[13:0], sdi_s2_r};
            ld_nxt   = sh_r[14];
            cnt_nxt  = 4'h0;
            st_nxt   = acr_pkg::ST_DATA;
          end
        end
      acr_pkg::ST_DATA:
      begin
        // Streaming moves to the next byte address after each access
        if (ld_r)
        begin
          tx_nxt   = cfg.rdata;
          addr_nxt = addr_r + 15'h0001;
        end
        if (wr_r)
          addr_nxt = addr_r + 15'h0001;
        if (rise)
        begin
          sh_nxt  = {sh_r[14:0], sdi_s2_r};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == acr_pkg::BYTE_LAST)
          begin
            cnt_nxt = 4'h0;
            wr_nxt  = ~rw_r;
            ld_nxt  = rw_r;
            wd_nxt  = {sh_r[6:0], sdi_s2_r};
          end
        end
        // Uses the freshly loaded byte if load and edge coincide
        if (fall && rw_r)
        begin
          sdo_nxt = tx_nxt[7];
          tx_nxt  = {tx_nxt[6:0], 1'b0};
        end
      end
      default: st_nxt = acr_pkg::ST_IDLE;
    endcase
    if (cs_s2_r)
    begin
      st_nxt = acr_pkg::ST_IDLE;
      ld_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r   <= acr_pkg::ST_IDLE;
      cnt_r  <= 4'h0;
      sh_r   <= 16'h0000;
      rw_r   <= 1'b0;
      addr_r <= 15'h0000;
      wr_r   <= 1'b0;
      ld_r   <= 1'b0;
      tx_r   <= 8'h00;
      sdo_r  <= 1'b0;
      wd_r   <= 8'h00;
    end
    else
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      rw_r   <= rw_nxt;
      addr_r <= addr_nxt;
      wr_r   <= wr_nxt;
      ld_r   <= ld_nxt;
      tx_r   <= tx_nxt;
      sdo_r  <= sdo_nxt;
      wd_r   <= wd_nxt;
    end
  end
  assign cfg.wr_en = wr_r;
  assign cfg.addr  = addr_r;
  assign cfg.wdata = wd_r;
  assign sdo       = sdo_r;
  assign sdo_oe    = rw_r & (st_r == acr_pkg::ST_DATA) & ~cs_s2_r;
endmodule // acr_spi_port
`default_nettype wire

//--- inc/acr_cfg_if.sv
// Byte access path between the serial port and the register bank
`timescale 1ns/1ns
`default_nettype none
interface acr_cfg_if;
  logic        wr_en;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport port (output wr_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- inc/acr_pkg.sv
// Constants and types shared by the clock and range register bank
`default_nettype none
package acr_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_DELAY_CTRL = 15'h0029;
  localparam logic [14:0] ADDR_CLK_IN     = 15'h002a;
  localparam logic [14:0] ADDR_SUPPLY     = 15'h002b;
  localparam logic [14:0] ADDR_POS0       = 15'h002c;
  localparam logic [14:0] ADDR_POS1       = 15'h002d;
  localparam logic [14:0] ADDR_POS2       = 15'h002e;
  localparam logic [14:0] ADDR_FS0        = 15'h0030;
  localparam logic [14:0] ADDR_FS1        = 15'h0031;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_DELAY_CTRL  = 8'h80;
  localparam logic [7:0]  RST_CLK_IN      = 8'h00;
  localparam logic [7:0]  RST_SUPPLY      = 8'h10;
  localparam logic [23:0] RST_POS         = 24'h000000;
  localparam logic [15:0] RST_FS          = 16'ha000;
  // ----------------------------------------------------------------
  // Field positions and limits
  // ----------------------------------------------------------------
  localparam int BIT_DEVICE_SAMPLE_CLOCK_PECL   = 2;
  localparam int BIT_ALIGNREF_PECL = 1;
  localparam int BIT_ALIGNREF_INV  = 0;
  localparam int BIT_QUANT_QUIET   = 2;
  localparam int BIT_CLKPATH_QUIET = 0;
  localparam int DSEL_MSB          = 3;
  localparam int DELAY_TAPS        = 16;
  localparam logic [15:0] FS_MIN_RECOMMENDED = 16'h2000;
  // ----------------------------------------------------------------
  // Serial port framing
  // ----------------------------------------------------------------
  localparam logic [3:0] HDR_LAST  = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HDR  = 3'b010,
    ST_DATA = 3'b100
  } acr_spi_state_t;
endpackage
`default_nettype wire

//--- tb/acr_testbench.sv
// Self-checking bench for the clock and range register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic        mclk;
  logic        srst;
  logic        sclk;
  logic        scs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        ref_in;
  logic [23:0] pos_in;
  logic        dev_pecl;
  logic        ref_pecl;
  logic        ref_inv;
  logic        quant_q;
  logic        clkp_q;
  logic [3:0]  dsel;
  logic        aligned;
  logic [15:0] fs;
  logic        degraded;
  logic [15:0] scratch;
  int          errors;
  int          checks;
  int          lat0;
  int          lat3;
  int          lat9;
  logic [7:0]  supply_vals [4] = '{8'h14, 8'h11, 8'h15, 8'h10};

  acr_clock_range_regs uut (
    .MCLK                             (mclk),
    .SRST                             (srst),
    .SCLK                             (sclk),
    .SCS_N                            (scs_n),
    .SDI                              (sdi),
    .SDO                              (sdo),
    .SDO_OE                           (sdo_oe),
    .ALIGN_REF_IN                     (ref_in),
    .ALIGN_POS_IN                     (pos_in),
    .DEVCLOCK_PECL_MODE_ENABLE        (dev_pecl),
    .ALIGNREF_PECL_MODE_ENABLE        (ref_pecl),
    .ALIGNREF_POLARITY_INVERT         (ref_inv),
    .QUANTIZER_SUPPLY_QUIETING_ENABLE (quant_q),
    .CLOCKPATH_SUPPLY_QUIETING_ENABLE (clkp_q),
    .ALIGNREF_DELAY_SELECT            (dsel),
    .ALIGN_REF_ALIGNED                (aligned),
    .FULL_SCALE_SETTING               (fs),
    .FULL_SCALE_DEGRADED              (degraded)
  );

  initial
  begin
    mclk   = 1'b0;
    srst   = 1'b1;
    sclk   = 1'b0;
    scs_n  = 1'b1;
    sdi    = 1'b0;
    ref_in = 1'b0;
    pos_in = 24'h000000;
    errors = 0;
    checks = 0;
  end

  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Half periods of 8 clocks keep well clear of the 4 clock minimum
  task automatic frame(input logic [15:0] hdr, input logic [15:0] wd, input int nb,
                       output logic [15:0] got);
    logic [31:0] bits;
    bits = {hdr, wd};
    got = 16'h0000;
    @(posedge mclk);
    scs_n <= 1'b0;
    for (int i = 0; i < 16 + nb; i++)
    begin
      @(posedge mclk);
      sclk <= 1'b0;
      sdi  <= bits[31 - i];
      repeat (8) @(posedge mclk);
      if (i >= 16)
      begin
        got = {got[14:0], sdo};
        if (hdr[15])
          chk("sdo_oe in read", 24'h000001, {23'h0, sdo_oe});
      end
      sclk <= 1'b1;
      repeat (8) @(posedge mclk);
    end
    sclk <= 1'b0;
    repeat (8) @(posedge mclk);
    scs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [15:0] got;
    frame({1'b0, a}, {d, 8'h00}, 8, got);
  endtask

  task automatic rdb(input logic [14:0] a, input logic [7:0] exp);
    logic [15:0] got;
    frame({1'b1, a}, 16'h0000, 8, got);
    chk($sformatf("reg %h", a), {16'h0, exp}, {16'h0, got[7:0]});
  endtask

  // Edges from a pin rise to the aligned output rising
  task automatic measure(input logic [3:0] sel, output int lat);
    wr(acr_pkg::ADDR_DELAY_CTRL, {4'h8, sel});
    chk("delay select", {20'h0, sel}, {20'h0, dsel});
    @(posedge mclk);
    ref_in <= 1'b1;
    lat = 0;
    while (aligned !== 1'b1 && lat < 40)
    begin
      @(posedge mclk);
      lat++;
    end
    ref_in <= 1'b0;
    repeat (40) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rdb(acr_pkg::ADDR_DELAY_CTRL, 8'h80);
    rdb(acr_pkg::ADDR_CLK_IN, 8'h00);
    rdb(acr_pkg::ADDR_SUPPLY, 8'h10);
    rdb(acr_pkg::ADDR_POS0, 8'h00);
    rdb(acr_pkg::ADDR_FS0, 8'h00);
    rdb(acr_pkg::ADDR_FS1, 8'ha0);
    chk("full scale", 24'h00a000, {8'h0, fs});
    wr(15'h0040, 8'hff);
    rdb(15'h0040, 8'h00);
    chk("sdo_oe idle", 24'h000000, {23'h0, sdo_oe});
    $display("test reset_values done");

    for (int i = 0; i < 3; i++)
    begin
      wr(acr_pkg::ADDR_CLK_IN, 8'h01 << i);
      chk("clock input bits", 24'h1 << i, {21'h0, dev_pecl, ref_pecl, ref_inv});
      rdb(acr_pkg::ADDR_CLK_IN, 8'h01 << i);
    end
    // Aborted write: four data bits then chip select released
    frame({1'b0, acr_pkg::ADDR_CLK_IN}, 16'h0000, 4, scratch);
    chk("aborted write", 24'h000001, {23'h0, dev_pecl});
    $display("test clock_input done");

    foreach (supply_vals[k])
    begin
      wr(acr_pkg::ADDR_SUPPLY, supply_vals[k]);
      chk("supply quieting", {22'h0, supply_vals[k][2], supply_vals[k][0]},
          {22'h0, quant_q, clkp_q});
      rdb(acr_pkg::ADDR_SUPPLY, supply_vals[k]);
    end
    $display("test supply done");

    pos_in <= 24'h5a3c81;
    repeat (4) @(posedge mclk);
    rdb(acr_pkg::ADDR_POS0, 8'h81);
    rdb(acr_pkg::ADDR_POS1, 8'h3c);
    rdb(acr_pkg::ADDR_POS2, 8'h5a);
    wr(acr_pkg::ADDR_POS0, 8'hff);
    rdb(acr_pkg::ADDR_POS0, 8'h81);
    pos_in <= 24'h0f00a5;
    repeat (4) @(posedge mclk);
    rdb(acr_pkg::ADDR_POS0, 8'ha5);
    // Delay select picked from the low nibble of the position read back
    wr(acr_pkg::ADDR_DELAY_CTRL, {4'h8, 4'h5});
    chk("delay select from position", 24'h000005, {20'h0, dsel});
    $display("test position done");

    frame({1'b0, acr_pkg::ADDR_FS0}, 16'h0020, 16, scratch);
    chk("full scale min", 24'h002000, {8'h0, fs});
    chk("degraded min", 24'h000000, {23'h0, degraded});
    wr(acr_pkg::ADDR_FS0, 8'hff);
    wr(acr_pkg::ADDR_FS1, 8'h1f);
    chk("full scale low", 24'h001fff, {8'h0, fs});
    chk("degraded low", 24'h000001, {23'h0, degraded});
    frame({1'b0, acr_pkg::ADDR_FS0}, 16'hffff, 16, scratch);
    chk("full scale max", 24'h00ffff, {8'h0, fs});
    chk("degraded max", 24'h000000, {23'h0, degraded});
    rdb(acr_pkg::ADDR_FS1, 8'hff);
    $display("test full_scale done");

    wr(acr_pkg::ADDR_CLK_IN, 8'h00);
    measure(4'h0, lat0);
    measure(4'h3, lat3);
    measure(4'h9, lat9);
    chk("latency step", 24'd9, 24'(lat9 - lat0));
    chk("latency step three", 24'd3, 24'(lat3 - lat0));
    // Two sync flops, tap zero, output flop, plus one edge of sampling lag
    chk("latency base", 24'd5, 24'(lat0));
    wr(acr_pkg::ADDR_CLK_IN, 8'h01);
    repeat (30) @(posedge mclk);
    chk("inverted reference", 24'h000001, {23'h0, aligned});
    $display("test alignment done");
    report_and_stop();
  end

  // Roughly 17k cycles of traffic expected; limit set well beyond
  initial
  begin
    repeat (60000) @(posedge mclk);
    errors++;
    $display("BAD watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
